// [pkg/vrt_regs.vh]
/*
 * Register indices, field positions and reset values of the vertical raster timing block.
 * Assumes byte address = 4 * index on an APB bus with 32-bit data.
 */
`ifndef VRT_REGS_VH
`define VRT_REGS_VH

// register indices; byte address is four times the index
`define VRT_IDX_EXT_CTRL        10'h00c
`define VRT_IDX_FRAME_PERIOD    10'h090
`define VRT_IDX_SYNC_WIDTH      10'h091
`define VRT_IDX_BORDER_START    10'h092
`define VRT_IDX_DISPLAY_START   10'h093
`define VRT_IDX_DISPLAY_END     10'h094
`define VRT_IDX_BORDER_END      10'h095
`define VRT_IDX_CURSOR_START    10'h096
`define VRT_IDX_CURSOR_END      10'h097
`define VRT_IDX_COUNT_LOAD      10'h098
`define VRT_IDX_COUNT_STEP      10'h09a
`define VRT_IDX_BROADCAST       10'h09c
`define VRT_IDX_STATUS          10'h0a0

// address code carried in the top bits of each written word
`define VRT_CODE_MSB            31
`define VRT_CODE_LSB            24
`define VRT_EXT_CODE_LSB        28
`define VRT_EXT_CODE            4'hc

// field layout
`define VRT_RASTER_W            13
`define VRT_CURSOR_W            15
`define VRT_CMODE_MSB           14
`define VRT_CMODE_LSB           13
`define VRT_EXT_W               28
`define VRT_EXT_PINS_MSB        1
`define VRT_EXT_PORT_MSB        7
`define VRT_EXT_PORT_LSB        4
`define VRT_HS_CFG_MSB          9
`define VRT_HS_CFG_LSB          8
`define VRT_VS_CFG_MSB          11
`define VRT_VS_CFG_LSB          10
`define VRT_PORT_SEL_EXPORT     2'h3

// cursor half-screen modes
`define VRT_CMODE_NORMAL        2'h0
`define VRT_CMODE_UPPER         2'h1
`define VRT_CMODE_LOWER         2'h2
`define VRT_CMODE_SPLIT         2'h3

// reset values
`define VRT_RST_RASTER          13'h0000
`define VRT_RST_CURSOR          15'h0000
`define VRT_RST_EXT             28'h0000000

`endif

// [logic/vrt_timing.v]
/*
 * Vertical raster timing: threshold registers, raster counter, sync, display,
 * border and cursor windows, production test writes and external control register.
 * Assumes an APB master, and a raster_tick pulse from the horizontal timing at each
 * horizontal sync start.
 */
// Behaviour
// - display-start threshold, 13 bits, rasters from sync start minus one
// - display-end threshold, 13 bits, first raster without video minus one
// - border-end threshold, 13 bits, first raster without border minus one
// - cursor-start register 15 bits; low 13 bits are raster start minus one
// - top two cursor-start bits pick normal, upper, lower or split cursor
// - split: lower half display start to cursor start, upper cursor end to display end
// - cursor-end threshold, 13 bits, first raster without cursor minus one
// - a load test write puts the 13-bit value into the raster counter
// - any step test write advances the raster counter by one
// - a broadcast test write puts the value into every vertical threshold register, not the raster counter
// - external control bits one and zero drive two dedicated pins
// - external bits seven to four drive upper port lines when select equals three
// - separate external fields choose horizontal and vertical sync configuration
// - frame period holds rasters per frame minus two; counter wraps after reaching that value plus one
// - sync width holds pulse rasters minus one; sync active up to and including the raster equal to it
// - border-start holds rasters from sync start to border minus one
`timescale 1ns/1ps
`include "vrt_regs.vh"

module vrt_timing (
	clk,                      // 200 MHz clock
	reset_n,                  // asynchronous reset, active low
	psel,                     // apb select
	penable,                  // apb enable
	pwrite,                   // apb direction, high for write
	paddr,                    // apb byte address
	pwdata,                   // apb write data
	prdata,                   // apb read data
	pready,                   // apb ready
	pslverr,                  // apb error
	raster_tick,              // one-cycle pulse at each raster start
	port_select_inputs,       // external port select inputs
	vert_sync,                // vertical sync, high during pulse
	display_active,           // display window
	border_active,            // border window
	cursor_active,            // cursor window
	ext_ctrl_pins,            // dedicated pins from external control
	external_port_lines,      // upper four external port lines
	external_port_lines_oe,   // drive enable of the upper port lines
	hsync_config_field,       // horizontal sync configuration
	vsync_config_field        // vertical sync configuration
);
	input  wire        clk;
	input  wire        reset_n;
	input  wire        psel;
	input  wire        penable;
	input  wire        pwrite;
	input  wire [11:0] paddr;
	input  wire [31:0] pwdata;
	output reg  [31:0] prdata;
	output reg         pready;
	output reg         pslverr;
	input  wire        raster_tick;
	input  wire [1:0]  port_select_inputs;
	output reg         vert_sync;
	output reg         display_active;
	output reg         border_active;
	output reg         cursor_active;
	output reg  [1:0]  ext_ctrl_pins;
	output reg  [3:0]  external_port_lines;
	output reg         external_port_lines_oe;
	output reg  [1:0]  hsync_config_field;
	output reg  [1:0]  vsync_config_field;

	localparam RW = `VRT_RASTER_W;

	reg  [1:0]    rst_sync_r;
	wire          rst_n;
	reg  [RW-1:0] frame_period_rasters_r;
	reg  [RW-1:0] vert_sync_width_r;
	reg  [RW-1:0] border_start_rasters_r;
	reg  [RW-1:0] display_start_rasters_r;
	reg  [RW-1:0] display_end_rasters_r;
	reg  [RW-1:0] border_end_rasters_r;
	reg  [`VRT_CURSOR_W-1:0] cursor_start_rasters_r;
	reg  [RW-1:0] cursor_end_rasters_r;
	reg  [`VRT_EXT_W-1:0]    ext_ctrl_r;
	reg  [RW-1:0] vcount_r;
	reg  [RW-1:0] vcount_nxt;
	wire [9:0]    idx;
	wire          access;
	wire          wr_take;
	reg           mapped;
	reg           code_ok;
	reg  [31:0]   rdata_nxt;
	wire [RW-1:0] wval;
	wire [1:0]    cmode;
	wire [RW:0]   mid_sum;
	wire [RW-1:0] mid;
	wire          upper_half;
	reg           cursor_nxt;

	// true when raster c lies in the window that starts after s and ends at e
	function in_span;
		input [RW-1:0] c;
		input [RW-1:0] s;
		input [RW-1:0] e;
		begin
			in_span = (c > s) && (c <= e);
		end
	endfunction

	// raster after c; the step test write does not wrap
	function [RW-1:0] next_raster;
		input [RW-1:0] c;
		begin
			next_raster = c + 13'h0001;
		end
	endfunction

	// last raster of the frame; one bit wider so the largest period cannot wrap to zero
	function frame_last;
		input [RW-1:0] c;
		input [RW-1:0] p;
		begin
			frame_last = ({1'b0, c} >= ({1'b0, p} + 14'h0001));
		end
	endfunction

	// read word of a 13-bit register, upper bits zero
	function [31:0] word13;
		input [RW-1:0] v;
		begin
			word13 = {19'h00000, v};
		end
	endfunction

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	assign idx     = paddr[11:2];
	assign access  = psel && penable && !pready;
	assign wr_take = psel && penable && pready && pwrite && mapped && code_ok;
	assign wval    = pwdata[RW-1:0];

	// address decode and code check of the written word
	// reads ignore the code; a write with a wrong code is refused and has no effect
	always @* begin
		mapped  = 1'b1;
		code_ok = (pwdata[`VRT_CODE_MSB:`VRT_CODE_LSB] == idx[7:0]);
		if (paddr[1:0] != 2'b00)
			mapped = 1'b0;
		else if (idx == `VRT_IDX_EXT_CTRL)
			code_ok = (pwdata[`VRT_CODE_MSB:`VRT_EXT_CODE_LSB] == `VRT_EXT_CODE);
		else if (idx >= `VRT_IDX_FRAME_PERIOD && idx <= `VRT_IDX_COUNT_LOAD)
			mapped = 1'b1;
		else if (idx == `VRT_IDX_COUNT_STEP || idx == `VRT_IDX_BROADCAST)
			mapped = 1'b1;
		else if (idx == `VRT_IDX_STATUS)
			code_ok = 1'b0;
		else
			mapped = 1'b0;
	end

	always @* begin
		rdata_nxt = 32'h00000000;
		if (idx == `VRT_IDX_EXT_CTRL)
			rdata_nxt = {4'h0, ext_ctrl_r};
		else if (idx == `VRT_IDX_FRAME_PERIOD)
			rdata_nxt = word13(frame_period_rasters_r);
		else if (idx == `VRT_IDX_SYNC_WIDTH)
			rdata_nxt = word13(vert_sync_width_r);
		else if (idx == `VRT_IDX_BORDER_START)
			rdata_nxt = word13(border_start_rasters_r);
		else if (idx == `VRT_IDX_DISPLAY_START)
			rdata_nxt = word13(display_start_rasters_r);
		else if (idx == `VRT_IDX_DISPLAY_END)
			rdata_nxt = word13(display_end_rasters_r);
		else if (idx == `VRT_IDX_BORDER_END)
			rdata_nxt = word13(border_end_rasters_r);
		else if (idx == `VRT_IDX_CURSOR_START)
			rdata_nxt = {17'h00000, cursor_start_rasters_r};
		else if (idx == `VRT_IDX_CURSOR_END)
			rdata_nxt = word13(cursor_end_rasters_r);
		else if (idx == `VRT_IDX_STATUS)
			rdata_nxt = {15'h0000, cursor_active, border_active, display_active,
				vert_sync, vcount_r};
	end

	// one wait state: pready rises in the second access cycle
	// prdata and pslverr are zero outside the ready cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= access;
			pslverr <= access && (!mapped || (pwrite && !code_ok));
			prdata  <= (access && !pwrite && mapped) ? rdata_nxt : 32'h00000000;
		end
	end

	// threshold registers and external control
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_period_rasters_r  <= `VRT_RST_RASTER;
			vert_sync_width_r       <= `VRT_RST_RASTER;
			border_start_rasters_r  <= `VRT_RST_RASTER;
			display_start_rasters_r <= `VRT_RST_RASTER;
			display_end_rasters_r   <= `VRT_RST_RASTER;
			border_end_rasters_r    <= `VRT_RST_RASTER;
			cursor_start_rasters_r  <= `VRT_RST_CURSOR;
			cursor_end_rasters_r    <= `VRT_RST_RASTER;
			ext_ctrl_r              <= `VRT_RST_EXT;
		end else if (wr_take) begin
			if (idx == `VRT_IDX_EXT_CTRL)
				ext_ctrl_r <= pwdata[`VRT_EXT_W-1:0];
			else if (idx == `VRT_IDX_FRAME_PERIOD)
				frame_period_rasters_r <= wval;
			else if (idx == `VRT_IDX_SYNC_WIDTH)
				vert_sync_width_r <= wval;
			else if (idx == `VRT_IDX_BORDER_START)
				border_start_rasters_r <= wval;
			else if (idx == `VRT_IDX_DISPLAY_START)
				display_start_rasters_r <= wval;
			else if (idx == `VRT_IDX_DISPLAY_END)
				display_end_rasters_r <= wval;
			else if (idx == `VRT_IDX_BORDER_END)
				border_end_rasters_r <= wval;
			else if (idx == `VRT_IDX_CURSOR_START)
				cursor_start_rasters_r <= pwdata[`VRT_CURSOR_W-1:0];
			else if (idx == `VRT_IDX_CURSOR_END)
				cursor_end_rasters_r <= wval;
			else if (idx == `VRT_IDX_BROADCAST) begin
				// half-screen mode bits are not vertical timing and keep their value
				frame_period_rasters_r  <= wval;
				vert_sync_width_r       <= wval;
				border_start_rasters_r  <= wval;
				display_start_rasters_r <= wval;
				display_end_rasters_r   <= wval;
				border_end_rasters_r    <= wval;
				cursor_start_rasters_r[RW-1:0] <= wval;
				cursor_end_rasters_r    <= wval;
			end
		end
	end

	// raster counter: test writes win over the raster tick
	always @* begin
		vcount_nxt = vcount_r;
		if (wr_take && idx == `VRT_IDX_COUNT_LOAD)
			vcount_nxt = wval;
		else if (wr_take && idx == `VRT_IDX_COUNT_STEP)
			vcount_nxt = next_raster(vcount_r);
		else if (raster_tick) begin
			if (frame_last(vcount_r, frame_period_rasters_r))
				vcount_nxt = 13'h0000;
			else
				vcount_nxt = next_raster(vcount_r);
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			vcount_r <= `VRT_RST_RASTER;
		else
			vcount_r <= vcount_nxt;
	end

	// half-screen boundary sits midway through the displayed rasters
	assign cmode      = cursor_start_rasters_r[`VRT_CMODE_MSB:`VRT_CMODE_LSB];
	assign mid_sum    = {1'b0, display_start_rasters_r} + {1'b0, display_end_rasters_r};
	assign mid        = mid_sum[RW:1];
	assign upper_half = (vcount_r <= mid);

	always @* begin
		cursor_nxt = 1'b0;
		case (cmode)
		`VRT_CMODE_NORMAL: begin
			cursor_nxt = in_span(vcount_r, cursor_start_rasters_r[RW-1:0],
				cursor_end_rasters_r);
		end
		`VRT_CMODE_UPPER: begin
			cursor_nxt = upper_half && in_span(vcount_r,
				cursor_start_rasters_r[RW-1:0], cursor_end_rasters_r);
		end
		`VRT_CMODE_LOWER: begin
			cursor_nxt = !upper_half && in_span(vcount_r,
				cursor_start_rasters_r[RW-1:0], cursor_end_rasters_r);
		end
		default: begin
			cursor_nxt = (!upper_half && in_span(vcount_r, display_start_rasters_r,
				cursor_start_rasters_r[RW-1:0])) ||
				(upper_half && in_span(vcount_r, cursor_end_rasters_r,
				display_end_rasters_r));
		end
		endcase
	end

	// windows and pins, registered one cycle after the counter
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vert_sync              <= 1'b0;
			display_active         <= 1'b0;
			border_active          <= 1'b0;
			cursor_active          <= 1'b0;
			ext_ctrl_pins          <= 2'b00;
			external_port_lines    <= 4'h0;
			external_port_lines_oe <= 1'b0;
			hsync_config_field     <= 2'b00;
			vsync_config_field     <= 2'b00;
		end else begin
			vert_sync      <= (vcount_r <= vert_sync_width_r);
			display_active <= in_span(vcount_r, display_start_rasters_r,
				display_end_rasters_r);
			border_active  <= in_span(vcount_r, border_start_rasters_r,
				border_end_rasters_r);
			cursor_active  <= cursor_nxt;
			ext_ctrl_pins  <= ext_ctrl_r[`VRT_EXT_PINS_MSB:0];
			if (port_select_inputs == `VRT_PORT_SEL_EXPORT) begin
				external_port_lines    <= ext_ctrl_r[`VRT_EXT_PORT_MSB:`VRT_EXT_PORT_LSB];
				external_port_lines_oe <= 1'b1;
			end else begin
				external_port_lines    <= 4'h0;
				external_port_lines_oe <= 1'b0;
			end
			hsync_config_field <= ext_ctrl_r[`VRT_HS_CFG_MSB:`VRT_HS_CFG_LSB];
			vsync_config_field <= ext_ctrl_r[`VRT_VS_CFG_MSB:`VRT_VS_CFG_LSB];
		end
	end

endmodule

// [test/vrt_timing_assertions.sv]
/* Concurrent checks on the ports of the vertical raster timing block.
 * Bound to every vrt_timing instance; sees only its ports, one clock domain. */
`timescale 1ns/1ps
`include "vrt_regs.vh"
module vrt_timing_assertions (
	input wire        clk, reset_n, psel, penable, pwrite, pready, pslverr, // clock, apb
	input wire [11:0] paddr,                                                // byte address
	input wire [31:0] pwdata, prdata,                                       // apb data
	input wire        raster_tick, vert_sync, display_active, border_active, // timing
	input wire        cursor_active, external_port_lines_oe,                // window, enable
	input wire [1:0]  port_select_inputs, ext_ctrl_pins,                    // port select, pins
	input wire [1:0]  hsync_config_field, vsync_config_field,               // sync config
	input wire [3:0]  external_port_lines                                   // upper port lines
);
	reg  [11:0] ext_d;
	wire        acc = psel && penable && pready;
	wire        extw = acc && pwrite && paddr == 12'h030 && pwdata[31:28] == `VRT_EXT_CODE;
	wire        vwr = acc && pwrite && paddr[11:2] >= 10'h090 && paddr[11:2] <= 10'h097;
	// last accepted external control value, for the output checks
	always @(posedge clk) begin
		if (extw)
			ext_d <= pwdata[11:0];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	one_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("answer not after one wait state");
	code_refuse_a: assert property (vwr && pwdata[31:24] != paddr[9:2] |-> pslverr)
		else $error("wrong code accepted");
	good_write_a: assert property (vwr && paddr[1:0] == 2'h0 && pwdata[31:24] == paddr[9:2]
		|-> !pslverr) else $error("valid write refused");
	unaligned_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access accepted");
	pins_follow_a: assert property (extw |=> ##1 ext_ctrl_pins == ext_d[1:0])
		else $error("dedicated pins wrong");
	sync_cfg_a: assert property (extw |=> ##1 hsync_config_field == ext_d[9:8]
		&& vsync_config_field == ext_d[11:10]) else $error("sync config wrong");
	port_off_a: assert property ((port_select_inputs != 2'h3) [*2] |->
		!external_port_lines_oe && external_port_lines == 4'h0) else $error("port driven");
	port_on_a: assert property ((port_select_inputs == 2'h3) [*2]
		|-> external_port_lines_oe) else $error("port not driven");
	prdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
endmodule
bind vrt_timing vrt_timing_assertions i_vrt_timing_assertions (.clk(clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .raster_tick(raster_tick),
	.vert_sync(vert_sync), .display_active(display_active), .border_active(border_active),
	.cursor_active(cursor_active), .external_port_lines_oe(external_port_lines_oe),
	.port_select_inputs(port_select_inputs), .ext_ctrl_pins(ext_ctrl_pins),
	.hsync_config_field(hsync_config_field), .vsync_config_field(vsync_config_field),
	.external_port_lines(external_port_lines));

// [test/vrt_raster_src.sv]
/* Far side model: raster start source and display sink capturing twenty rasters.
 * Assumes the block's outputs settle within four clocks of a raster start. */
`timescale 1ns/1ps
module vrt_raster_src (
	input  wire         clk,                                                   // bench clock
	input  wire         run,                                                   // start capture
	input  wire         vert_sync, display_active, border_active, cursor_active, // from block
	output logic        raster_tick,                                           // raster start
	output logic        done,                                                  // capture over
	output logic [79:0] seen                                                   // per raster
);
	int i;
	initial begin
		raster_tick = 1'b0;
		done = 1'b0;
		seen = '0;
		forever begin
			@(posedge clk);
			if (!run)
				done <= 1'b0;
			else if (!done) begin
				for (i = 0; i < 20; i++) begin
					repeat (4) @(posedge clk);
					seen[i] <= vert_sync;
					seen[20 + i] <= display_active;
					seen[40 + i] <= border_active;
					seen[60 + i] <= cursor_active;
					@(posedge clk);
					raster_tick <= 1'b1;
					@(posedge clk);
					raster_tick <= 1'b0;
				end
				done <= 1'b1;
			end
		end
	end
endmodule

// [test/tb.sv]
/* Self-checking bench: APB register traffic, test writes, frame capture, external control.
 * Needs vrt_regs.vh on the include path. */
`timescale 1ns/1ps
`include "vrt_regs.vh"
module tb;
	logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        run = 1'b0, pready, pslverr, raster_tick, done, er;
	logic        vert_sync, display_active, border_active, cursor_active, external_port_lines_oe;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic [1:0]  port_select_inputs = 2'h0, ext_ctrl_pins, hsync_config_field, vsync_config_field;
	logic [3:0]  external_port_lines;
	logic [79:0] seen;
	logic [9:0]  curs_exp [4] = '{10'h070, 10'h010, 10'h060, 10'h078};
	logic [12:0] prog [6] = '{13'h8, 13'h1, 13'h0, 13'h1, 13'h8, 13'h9};
	int          n_errors = 0, n_compared = 0, i;

	always #2.5 clk = ~clk;

	vrt_timing i_vrt_timing (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .raster_tick(raster_tick), .port_select_inputs(port_select_inputs),
		.vert_sync(vert_sync), .display_active(display_active), .border_active(border_active),
		.cursor_active(cursor_active), .ext_ctrl_pins(ext_ctrl_pins),
		.external_port_lines(external_port_lines), .external_port_lines_oe(external_port_lines_oe),
		.hsync_config_field(hsync_config_field), .vsync_config_field(vsync_config_field));
	vrt_raster_src i_vrt_raster_src (.clk(clk), .run(run), .vert_sync(vert_sync),
		.display_active(display_active), .border_active(border_active),
		.cursor_active(cursor_active), .raster_tick(raster_tick), .done(done), .seen(seen));

	task automatic end_of_test;
		if (n_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	// waits for pready however long it takes; only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic e);
		apb(1'b1, {idx, 2'b00}, d);
		check(er, e);
	endtask
	task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, {idx, 2'b00}, 32'h0);
		check(rv, exp);
		check(er, 1'b0);
	endtask
	// one cursor mode, counter restarted at zero, two frames captured
	task automatic frame(input logic [1:0] m, input logic [12:0] cs, input logic [12:0] ce,
		input logic [9:0] bx);
		wr(10'h096, {8'h96, 9'h0, m, cs}, 1'b0);
		wr(10'h097, {8'h97, 11'h0, ce}, 1'b0);
		wr(10'h098, 32'h98000000, 1'b0);
		run <= 1'b1;
		while (done !== 1'b1)
			@(posedge clk);
		run <= 1'b0;
		check(seen[19:0], 32'h00c03);
		check(seen[39:20], {2{10'h1fc}});
		check(seen[59:40], {2{bx}});
		check(seen[79:60], {2{curs_exp[m]}});
		repeat (2) @(posedge clk);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (i = 'h90; i <= 'h97; i++)
			rd(i[9:0], 32'h0);
		for (i = 'h90; i <= 'h97; i++) begin
			wr(i[9:0], {i[7:0], 24'hffffff}, 1'b0);
			rd(i[9:0], i == 'h96 ? 32'h7fff : 32'h1fff);
		end
		wr(10'h093, 32'h94000005, 1'b1);
		rd(10'h093, 32'h1fff);
		apb(1'b0, 12'h24d, 32'h0);
		check(er, 1'b1);
		apb(1'b0, 12'h284, 32'h0);
		check(er, 1'b1);
		wr(10'h09c, 32'h9c000abc, 1'b0);
		for (i = 'h90; i <= 'h97; i++)
			rd(i[9:0], i == 'h96 ? 32'h6abc : 32'h0abc);
		wr(10'h098, 32'h98000123, 1'b0);
		apb(1'b0, 12'h280, 32'h0);
		check(rv[12:0], 13'h0123);
		wr(10'h09a, 32'h9a001fff, 1'b0);
		apb(1'b0, 12'h280, 32'h0);
		check(rv[12:0], 13'h0124);
		for (i = 0; i < 6; i++)
			wr(10'h090 + i[9:0], {8'h90 + i[7:0], 11'h0, prog[i]}, 1'b0);
		for (i = 0; i < 4; i++)
			frame(i[1:0], i == 3 ? 13'h6 : 13'h3, i == 3 ? 13'h2 : 13'h6,
				10'h3fe);
		// no border: border thresholds equal the display thresholds
		wr(10'h092, {8'h92, 11'h0, 13'h1}, 1'b0);
		wr(10'h095, {8'h95, 11'h0, 13'h8}, 1'b0);
		frame(2'h0, 13'h3, 13'h6, 10'h1fc);
		wr(10'h00c, 32'hc0000652, 1'b0);
		for (i = 0; i < 4; i++) begin
			port_select_inputs <= i[1:0];
			repeat (3) @(posedge clk);
			check({external_port_lines_oe, external_port_lines}, i == 3 ? 5'h15 : 5'h00);
			check(ext_ctrl_pins, 2'h2);
			check({vsync_config_field, hsync_config_field}, 4'h6);
		end
		end_of_test;
	end

	initial begin
		#60000;
		n_errors++;
		end_of_test;
	end
endmodule
